// File: spdp_map.vh
// Constants for the write-protection acknowledge logic
`ifndef SPDP_MAP_VH
`define SPDP_MAP_VH
`define SPDP_TYPE_MEM      4'ha
`define SPDP_TYPE_PROT     4'h6
`define SPDP_LOWER_LIMIT   8'h80
`define SPDP_SLOT_SOFT     2'h0
`define SPDP_SLOT_CLEAR    2'h1
`define SPDP_SLOT_PERM     2'h2
`define SPDP_ST_IDLE       2'h0
`define SPDP_ST_ADDR       2'h1
`define SPDP_ST_DATA       2'h2
`define SPDP_ST_DONE       2'h3
`define SPDP_OP_NONE       2'h0
`define SPDP_OP_SET        2'h1
`define SPDP_OP_CLEAR      2'h2
`define SPDP_OP_PERM       2'h3
`endif

// File: spdp_protect.v
// Write-protection acknowledge and write-cycle decision for a presence-detect EEPROM
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: Set and clear soft protect need the elevated voltage for the whole instruction.
// R2: Soft protection covers the lower 128 bytes; clear removes, permanent fixes it.
// R3: Permanently protected: write-form protection instructions get NoAck on every byte.
// R4: Protected: lower-half memory write acks control and address, NoAck data, no cycle.
// R5: Soft, inhibit low: repeat set NoAck; clear/permanent acked and written.
// R6: Soft, inhibit high: set NoAck; others ack control, address, NoAck data.
// R7: Unprotected: inhibit low acks all and writes; high refuses the data byte.
// R8: Read-form protection instructions ack control only when allowed, then NoAck.
// R9: Memory traffic responds only when chip-select pins match the select code slot bits.
// R10: Without elevated voltage the master can only use permanent protect.
// R11: Permanent protection is never undone by any instruction or pin level.
// R12: Protection instructions carry device type 0110 in the control byte.
// R13: Protection flags change only when their internal write cycle completes.
`include "spdp_map.vh"
module spdp_protect (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Byte stream from the bus framer
  input  wire       byte_valid,
  input  wire [7:0] byte_data,
  input  wire       frame_start,
  input  wire       frame_stop,
  // Pins
  input  wire       write_inhibit_pin,
  input  wire       chip_select_in0,
  input  wire       chip_select_in1,
  input  wire       chip_select_in2,
  input  wire       elevated_voltage_qualifier,
  // Internal write cycle handshake
  input  wire       write_cycle_done,
  // Answers
  output reg        ack_valid_q,
  output reg        ack_q,
  output reg        write_cycle_start_q,
  output reg        soft_protect_q,
  output reg        perm_protect_q
);
  // Frame tracking: byte position and what the control byte asked for
  reg [1:0] state_q;
  reg       is_prot_q;
  reg       is_read_q;
  reg [1:0] op_q;
  reg       hv_held_q;
  reg       data_ok_q;
  // Write cycle bookkeeping
  reg       arm_q;
  reg [1:0] pend_q;
  reg       busy_q;
  // Decode results of the current byte
  reg [1:0] op_d;
  reg       ctl_ok;
  reg       addr_ok;

  // Map protection slot bits to an instruction
  function [1:0] prot_op;
    input [1:0] slot;
    begin
      case (slot)
        `SPDP_SLOT_SOFT:  prot_op = `SPDP_OP_SET;
        `SPDP_SLOT_CLEAR: prot_op = `SPDP_OP_CLEAR;
        `SPDP_SLOT_PERM:  prot_op = `SPDP_OP_PERM;
        default:          prot_op = `SPDP_OP_NONE;
      endcase
    end
  endfunction

  // Memory bytes below this limit sit under soft protection
  function lower_half;
    input [7:0] addr;
    begin
      lower_half = (addr < `SPDP_LOWER_LIMIT);
    end
  endfunction

  // A soft set or clear is committed only with the qualifier held throughout
  function stop_may_write;
    input armed;
    input busy;
    input prot;
    input soft_op;
    input hv_ok;
    begin
      stop_may_write = armed && !busy && !(prot && soft_op && !hv_ok);
    end
  endfunction

  // Protection opcode travels in the slot bits; the select pins then do not gate it
  wire [3:0] dtype   = byte_data[7:4];
  wire       rw      = byte_data[0];
  // R9: slot match
  wire       sel_hit = (byte_data[3:1] == {chip_select_in2, chip_select_in1, chip_select_in0});
  // R12: type field
  wire       prot_ty = (dtype == `SPDP_TYPE_PROT);
  wire [1:0] pop     = prot_op(byte_data[2:1]);
  // Only set and clear need the elevated qualifier
  wire       is_soft_op = (op_q == `SPDP_OP_SET) || (op_q == `SPDP_OP_CLEAR);
  // Data byte granted: armed at address time and still not inhibited
  wire       data_grant = data_ok_q && !write_inhibit_pin;
  // Qualifier seen at every edge up to and including the stop
  wire       hv_whole   = hv_held_q && elevated_voltage_qualifier;

  always @* begin
    op_d    = pop;
    ctl_ok  = 1'b0;
    addr_ok = 1'b0;
    if (prot_ty) begin
      // R3 R8: permanent refuses all protection traffic
      if (perm_protect_q)
        ctl_ok = 1'b0;
      // R5 R6 R8: repeated set refused while soft protected
      else if (soft_protect_q && (pop == `SPDP_OP_SET))
        ctl_ok = 1'b0;
      else
        ctl_ok = (pop != `SPDP_OP_NONE);
    end else begin
      // Memory traffic must match the slot pins
      ctl_ok = (dtype == `SPDP_TYPE_MEM) && sel_hit;
    end
    // R8: read form acks control byte only
    addr_ok = !is_read_q;
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_q             <= `SPDP_ST_IDLE;
      is_prot_q           <= 1'b0;
      is_read_q           <= 1'b0;
      op_q                <= `SPDP_OP_NONE;
      hv_held_q           <= 1'b0;
      data_ok_q           <= 1'b0;
      arm_q               <= 1'b0;
      pend_q              <= `SPDP_OP_NONE;
      busy_q              <= 1'b0;
      ack_valid_q         <= 1'b0;
      ack_q               <= 1'b0;
      write_cycle_start_q <= 1'b0;
      // Power-up state; flags are the nonvolatile cells in the real part
      soft_protect_q      <= 1'b0;
      perm_protect_q      <= 1'b0;
    end else begin
      // Answer and start are one-cycle pulses
      ack_valid_q         <= 1'b0;
      write_cycle_start_q <= 1'b0;
      // R1: qualifier must stay high from start to stop
      if (!elevated_voltage_qualifier)
        hv_held_q <= 1'b0;
      // R13: commit flags on cycle completion
      if (busy_q && write_cycle_done) begin
        busy_q <= 1'b0;
        case (pend_q)
          `SPDP_OP_SET:   soft_protect_q <= 1'b1;
          // Clear leaves the flag up once permanent is set
          `SPDP_OP_CLEAR: soft_protect_q <= perm_protect_q;
          // R2 R11: permanent fixes soft protection for good
          `SPDP_OP_PERM: begin
            perm_protect_q <= 1'b1;
            soft_protect_q <= 1'b1;
          end
          default:        soft_protect_q <= soft_protect_q;
        endcase
      end
      // A repeated start restarts decoding but keeps a pending cycle
      if (frame_start) begin
        state_q   <= `SPDP_ST_IDLE;
        arm_q     <= 1'b0;
        hv_held_q <= elevated_voltage_qualifier;
      end else if (frame_stop) begin
        state_q <= `SPDP_ST_IDLE;
        arm_q   <= 1'b0;
        // Write only after the data byte was acked; soft set or clear also needs the qualifier held
        if (stop_may_write(arm_q, busy_q, is_prot_q, is_soft_op, hv_whole)) begin
          write_cycle_start_q <= 1'b1;
          busy_q              <= 1'b1;
          pend_q              <= is_prot_q ? op_q : `SPDP_OP_NONE;
        end
      // Busy device ignores bytes, so ack polling sees no answer
      end else if (byte_valid && !busy_q) begin
        case (state_q)
          `SPDP_ST_IDLE: begin
            is_prot_q   <= prot_ty;
            is_read_q   <= rw;
            op_q        <= op_d;
            // Refused control byte gives no answer pulse: NoAck
            ack_valid_q <= ctl_ok;
            ack_q       <= ctl_ok;
            state_q     <= ctl_ok ? `SPDP_ST_ADDR : `SPDP_ST_DONE;
          end
          `SPDP_ST_ADDR: begin
            ack_valid_q <= 1'b1;
            ack_q       <= addr_ok;
            // R4: lower half blocked when any protection is set
            data_ok_q   <= !write_inhibit_pin && !(!is_prot_q && soft_protect_q
                           && lower_half(byte_data));
            state_q     <= addr_ok ? `SPDP_ST_DATA : `SPDP_ST_DONE;
          end
          `SPDP_ST_DATA: begin
            // R6 R7: inhibit pin high refuses the data byte
            ack_valid_q <= 1'b1;
            ack_q       <= data_grant;
            arm_q       <= data_grant;
            // Page writes keep acking memory bytes; protection ends after one
            state_q     <= is_prot_q ? `SPDP_ST_DONE : `SPDP_ST_DATA;
          end
          `SPDP_ST_DONE: begin
            // Refused frames keep answering NoAck until the stop
            ack_valid_q <= 1'b1;
            ack_q       <= 1'b0;
          end
          default: state_q <= `SPDP_ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: spdp_protect_monitor.sv
// Checker for the protection acknowledge block
`timescale 1ns/10ps
`default_nettype none
`include "spdp_map.vh"
module spdp_protect_monitor (
  input wire logic core_clk, rst, byte_valid, frame_start, frame_stop, write_inhibit_pin,
  input wire logic chip_select_in0, chip_select_in1, chip_select_in2, write_cycle_done,
  input wire logic elevated_voltage_qualifier, ack_valid_q, ack_q, write_cycle_start_q,
  input wire logic soft_protect_q, perm_protect_q,
  input wire logic [7:0] byte_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_ack_has_byte: assert property (ack_valid_q |-> $past(byte_valid)) else $error("ack");
  a_start_on_stop: assert property (write_cycle_start_q |-> $past(frame_stop)) else $error("st");
  a_start_pulse: assert property (write_cycle_start_q |=> !write_cycle_start_q) else $error("p");
  a_inhibit_holds: assert property (write_cycle_start_q |-> !write_inhibit_pin) else $error("wi");
  a_perm_stays: assert property (perm_protect_q |=> perm_protect_q) else $error("perm");
  a_flag_on_done: assert property ($changed({soft_protect_q, perm_protect_q})
    |-> $past(write_cycle_done)) else $error("flag");
  a_soft_needs_hv: assert property ($rose(soft_protect_q) && !perm_protect_q
    |-> $past(elevated_voltage_qualifier)) else $error("hv");
  a_perm_refuses: assert property (perm_protect_q && byte_valid
    && byte_data[7:4] == `SPDP_TYPE_PROT && !byte_data[0] |=> !ack_valid_q) else $error("ref");
  c_write: cover property (write_cycle_start_q);
  c_soft: cover property ($rose(soft_protect_q));
  c_perm: cover property ($rose(perm_protect_q));
endmodule
bind spdp_protect spdp_protect_monitor i_spdp_protect_monitor (.*);
`default_nettype wire

// File: spdp_master_model.sv
// Bus master and write engine model
`timescale 1ns/10ps
`default_nettype none
module spdp_master_model #(parameter int DLY = 6) (
  input wire logic core_clk, ack_valid_q, ack_q, write_cycle_start_q,
  output logic byte_valid, frame_start, frame_stop, write_cycle_done,
  output logic [7:0] byte_data
);
  int cnt = 0;
  initial {byte_valid, frame_start, frame_stop, write_cycle_done, byte_data} = '0;
  always @(posedge core_clk) begin
    cnt <= write_cycle_start_q ? DLY : (cnt > 0 ? cnt - 1 : 0);
    write_cycle_done <= (cnt == 1);
  end
  task automatic xfer(input logic [7:0] c, a, d, output logic [2:0] k, output logic w);
    logic [7:0] b[3];
    b = '{c, a, d};
    @(posedge core_clk) frame_start <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk) {frame_start, byte_valid, byte_data} <= {2'b01, b[i]};
      // Released data line shows the inverse, not a stale byte
      @(posedge core_clk) {byte_valid, byte_data} <= {1'b0, ~b[i]};
      #1 k[2 - i] = ack_valid_q & ack_q;
    end
    @(posedge core_clk) frame_stop <= 1'b1;
    @(posedge core_clk) frame_stop <= 1'b0;
    #1 w = write_cycle_start_q;
    repeat (DLY + 4) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// File: spdp_tb.sv
// Testbench for the protection acknowledge block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk = 0, rst = 1, write_inhibit_pin = 0, elevated_voltage_qualifier = 0;
  logic chip_select_in0 = 1, chip_select_in1 = 0, chip_select_in2 = 1;
  logic byte_valid, frame_start, frame_stop, write_cycle_done, ack_valid_q, ack_q;
  logic write_cycle_start_q, soft_protect_q, perm_protect_q;
  logic [7:0] byte_data;
  int fail_count = 0, compares = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  spdp_protect i_spdp_protect (.*);
  spdp_master_model #(.DLY(6)) i_spdp_master_model (.*);
  task automatic run(input logic [7:0] c, a, input logic [5:0] e);
    logic [2:0] k;
    logic w;
    i_spdp_master_model.xfer(c, a, 8'h5a, k, w);
    compares++;
    if ({k, w, soft_protect_q, perm_protect_q} !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, {k, w, soft_protect_q, perm_protect_q}, e);
    end
  endtask
  task automatic pins(input logic wi, hv);
    @(posedge core_clk) {write_inhibit_pin, elevated_voltage_qualifier} <= {wi, hv};
  endtask
  task t_open;
    run(8'haa, 8'h10, 6'h3c);
    run(8'ha2, 8'h10, 6'h00);
    run(8'h61, 8'h00, 6'h20);
    pins(1, 1);
    run(8'h60, 8'h00, 6'h30);
    $display("open done");
  endtask
  task t_soft;
    pins(0, 1);
    run(8'h60, 8'h00, 6'h3e);
    run(8'h60, 8'h00, 6'h02);
    run(8'haa, 8'h7f, 6'h32);
    run(8'haa, 8'h80, 6'h3e);
    run(8'h63, 8'h00, 6'h22);
    pins(1, 1);
    run(8'h62, 8'h00, 6'h32);
    pins(0, 0);
    run(8'h62, 8'h00, 6'h3a);
    pins(0, 1);
    run(8'h62, 8'h00, 6'h3c);
    $display("soft done");
  endtask
  task t_perm;
    run(8'h60, 8'h00, 6'h3e);
    pins(0, 0);
    run(8'h64, 8'h00, 6'h3f);
    run(8'h64, 8'h00, 6'h03);
    pins(1, 1);
    run(8'h62, 8'h00, 6'h03);
    run(8'h65, 8'h00, 6'h03);
    run(8'haa, 8'h00, 6'h33);
    $display("perm done");
  endtask
  task print_verdict;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge core_clk) if (++cyc == 3000) begin
    fail_count++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 0;
    t_open;
    t_soft;
    t_perm;
    print_verdict;
  end
endmodule
`default_nettype wire
